//--- src/ring_fair_params.svh
// Constants for the ring fairness token block: offsets, fields, resets
// and timing. Included by the design modules; holds definitions only.
`ifndef RING_FAIR_PARAMS_SVH
`define RING_FAIR_PARAMS_SVH
// Widths of quota, transfer count and frame counter
`define QUOTA_W 8
`define XFER_W 4
`define CNT_W 12
// Token-loss time in ms and clock rate in kHz
`define SAT_LOSS_MS 100
`define CLK_KHZ 100000
// Register byte offsets on the APB slave
`define CFG_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define COUNT_OFFSET 8'h08
// Configuration register field positions
`define CFG_HOLD_LSB 0
`define CFG_IDLE_LSB 8
`define CFG_SPLIT_BIT 16
`define CFG_REFLECT_BIT 17
// Configuration reset values
`define RST_HOLD_QUOTA 8'h01
`define RST_IDLE_QUOTA 8'h04
`define RST_SPLIT 1'b0
`define RST_REFLECT 1'b0
`endif

//--- src/ring_fair_pkg.sv
// Types shared by the ring fairness token modules.
// Assumes nothing of its surroundings.
package ring_fair_pkg;
  // Token custody of one fairness engine
  typedef enum logic {TOK_FREE, TOK_HELD} tok_state_type;
endpackage

//--- src/fair_if.sv
// Link between the token router and one fairness engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fair_if #(
  parameter int QW = 8,
  parameter int XW = 4,
  parameter int CW = 12
);
  // Router to engine
  logic tok_in;
  logic tmr_clr;
  logic app_pending;
  logic no_cut;
  logic app_sent;
  logic [QW-1:0] hold_quota;
  logic [QW-1:0] idle_quota;
  logic [XW-1:0] xfer;
  // Engine to router
  logic tok_release;
  logic holding;
  logic satisfied;
  logic grant;
  logic [CW-1:0] cnt;
  modport eng (
    input tok_in, tmr_clr, app_pending, no_cut, app_sent,
    input hold_quota, idle_quota, xfer,
    output tok_release, holding, satisfied, grant, cnt
  );
  modport ctl (
    output tok_in, tmr_clr, app_pending, no_cut, app_sent,
    output hold_quota, idle_quota, xfer,
    input tok_release, holding, satisfied, grant, cnt
  );
endinterface

//--- src/sat_engine.sv
// Fairness engine for one token direction: custody, frame counter,
// scaled limits, Satisfied and the token-loss timer.
// Assumes the router gives it only tokens that arrived in sync.
`timescale 1ns/1ps
`include "ring_fair_params.svh"
module sat_engine #(
  parameter int CNT_W = `CNT_W,
  parameter int unsigned LOSS_CYCLES = `SAT_LOSS_MS * `CLK_KHZ
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Router side
  fair_if.eng f
);
  // Custody state
  ring_fair_pkg::tok_state_type state_reg;
  // Frame counter and scaled limits
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] hold_lim_reg;
  logic [CNT_W-1:0] idle_lim_reg;
  // Token-loss timer
  logic [31:0] loss_reg;
  logic loss_hit;
  logic tok_arrive;
  logic sat_now;
  logic release_now;

  // Loss timer fires only while no token is held
  assign loss_hit = (state_reg == ring_fair_pkg::TOK_FREE) &&
                    (loss_reg >= LOSS_CYCLES - 1);
  assign tok_arrive = f.tok_in | loss_hit;
  // quota met or nothing to send
  assign sat_now = (cnt_reg >= hold_lim_reg) ||
                   ((state_reg == ring_fair_pkg::TOK_HELD) &&
                    !f.app_pending);
  assign release_now = (state_reg == ring_fair_pkg::TOK_HELD) && sat_now;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_lim_reg <= '0;
      idle_lim_reg <= '0;
    end
    else
    begin
      // Both operands widened first so the product is not cut
      hold_lim_reg <= CNT_W'(f.hold_quota) * CNT_W'(f.xfer);
      idle_lim_reg <= CNT_W'(f.idle_quota) * CNT_W'(f.xfer);
    end
  end

  // Custody of the token
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= ring_fair_pkg::TOK_FREE;
    else
      case (state_reg)
        ring_fair_pkg::TOK_FREE:
          if (tok_arrive)
            state_reg <= ring_fair_pkg::TOK_HELD;
        ring_fair_pkg::TOK_HELD:
          if (release_now)
            state_reg <= ring_fair_pkg::TOK_FREE;
        default:
          state_reg <= ring_fair_pkg::TOK_FREE;
      endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= '0;
    else if (release_now)
      cnt_reg <= '0;
    else if (f.app_sent && (cnt_reg != {CNT_W{1'b1}}))
      cnt_reg <= cnt_reg + 1'b1;
  end

  // loss timer, restarted on SAT output
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      loss_reg <= '0;
    else if (f.tmr_clr || loss_hit)
      loss_reg <= '0;
    else if (loss_reg != 32'hFFFFFFFF)
      loss_reg <= loss_reg + 32'h1;
  end

  // nothing at or above idle limit
  assign f.grant = (cnt_reg < idle_lim_reg) &&
                   (((state_reg == ring_fair_pkg::TOK_HELD) && !sat_now) ||
                    f.no_cut);
  assign f.tok_release = release_now;
  assign f.holding = (state_reg == ring_fair_pkg::TOK_HELD);
  assign f.satisfied = sat_now;
  assign f.cnt = cnt_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_release_clears;
    f.tok_release |=> (cnt_reg == '0) && !f.holding;
  endproperty
  a_release_clears: assert property (p_release_clears)
    else $error("count not cleared after token release");
  property p_discard_second;
    f.holding && f.tok_in && !f.tok_release |=> f.holding;
  endproperty
  a_discard_second: assert property (p_discard_second)
    else $error("second token disturbed held token");
  property p_sat_release;
    f.holding && (cnt_reg >= hold_lim_reg) |-> f.tok_release;
  endproperty
  a_sat_release: assert property (p_sat_release)
    else $error("satisfied holder kept the token");
  property p_idle_block;
    (cnt_reg >= idle_lim_reg) |-> !f.grant;
  endproperty
  a_idle_block: assert property (p_idle_block)
    else $error("origination granted at idle limit");
  c_hold_then_release: cover property (
    f.tok_in && !f.holding ##1 f.holding [*3] ##1 f.tok_release);
endmodule

//--- src/ring_fairness_token_control.sv
// Ring fairness token control for a dual port node: two fairness
// engines, token forwarding and reflection, string-end handling,
// link idle detection and an APB register slave.
// Assumes the transmitter sends a requested token when ready and
// pulses the matching taken input; inputs are synchronous to ref_clk.
//
// Behaviour
// - Reflect flag chooses forward or reflect, node-wide
// - Forwarded SAT leaves on the other port
// - SAT' passes to opposite port without holding
// - Reflected SAT leaves on the arrival port
// - Reflect mode bounces SAT' back unconditionally
// - Two independent engines, one per direction
// - Satisfied passes token, else hold until Satisfied
// - Satisfied: hold limit reached or nothing pending
// - Limits are quota bases times open transfers
// - Count frames; clear on every token release
// - Count only after trailing flag; not aborts
// - Privileged and Control frames ignore fairness
// - Originate when holding unsatisfied or idle room
// - Below hold limit: yield to cut-through until token
// - Between limits: originate if idle, pass token
// - At idle limit: no origination until token
// - Accept tokens in sync, send only when Ready
// - String end returns released SAT as SAT'
// - String end returns SAT' as SAT immediately
// - Both ports up: forward SAT' unconditionally
// - Two consecutive FLAGs mark the link idle
// - Loss timer recreates SAT after timeout
// - Second SAT while holding is discarded
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "ring_fair_params.svh"
module ring_fairness_token_control #(
  parameter int unsigned LOSS_CYCLES = `SAT_LOSS_MS * `CLK_KHZ,
  parameter int QUOTA_W = `QUOTA_W,
  parameter int XFER_W = `XFER_W,
  parameter int CNT_W = `CNT_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link state per port
  input wire logic [1:0] rx_sync,
  input wire logic [1:0] port_ready,
  input wire logic [1:0] port_oper,
  // Received characters per port
  input wire logic [1:0] rx_sat,
  input wire logic [1:0] rx_sat_rev,
  input wire logic [1:0] rx_flag,
  input wire logic [1:0] rx_other,
  // Token transmit handshake per port
  output logic [1:0] tx_sat_req,
  output logic [1:0] tx_rev_req,
  input wire logic [1:0] tx_sat_taken,
  input wire logic [1:0] tx_rev_taken,
  // Application traffic per token direction
  input wire logic [1:0][XFER_W-1:0] xfer_count,
  input wire logic [1:0] app_pending,
  input wire logic [1:0] fwd_pending,
  input wire logic [1:0] app_sent,
  output logic [1:0] orig_grant,
  output logic [1:0] cut_stall,
  output logic [1:0] satisfied,
  // Configuration seen by the rest of the port
  output logic region_split
);
  // Configuration fields
  logic [QUOTA_W-1:0] hold_quota_reg;
  logic [QUOTA_W-1:0] idle_quota_reg;
  logic reflect_reg;
  // APB phases
  logic apb_setup;
  logic apb_write;
  logic addr_ok;
  logic [31:0] rd_value;
  // Per-port token traffic
  logic [1:0] tok_rel;
  logic [1:0] holding;
  logic [1:0] sat_now;
  logic [1:0] grant_now;
  logic [1:0] rev_in;
  logic [1:0] sat_set;
  logic [1:0] rev_set;
  logic [1:0] sat_pend_reg;
  logic [1:0] rev_pend_reg;
  logic [1:0] sat_pend_next;
  logic [1:0] rev_pend_next;
  // Link idle detection
  logic [1:0] flag_seen_reg;
  logic [1:0] link_idle_reg;
  logic [1:0][CNT_W-1:0] cnt;

  // Setup cycle of any transfer; write lands at access edge
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && pready;
  assign addr_ok = (paddr == `CFG_OFFSET) || (paddr == `STATUS_OFFSET) ||
                   (paddr == `COUNT_OFFSET);

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    rd_value = 32'h00000000;
    case (paddr)
      `CFG_OFFSET:
      begin
        rd_value[`CFG_HOLD_LSB +: QUOTA_W] = hold_quota_reg;
        rd_value[`CFG_IDLE_LSB +: QUOTA_W] = idle_quota_reg;
        rd_value[`CFG_SPLIT_BIT] = region_split;
        rd_value[`CFG_REFLECT_BIT] = reflect_reg;
      end
      `STATUS_OFFSET:
        rd_value = {20'h00000, rev_pend_reg, sat_pend_reg, link_idle_reg,
                    grant_now, sat_now, holding};
      `COUNT_OFFSET:
        rd_value = {16'(cnt[1]), 16'(cnt[0])};
      default:
        rd_value = 32'h00000000;
    endcase
  end

  // APB answer: zero wait states, data captured in setup
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (apb_setup)
      begin
        prdata <= pwrite ? 32'h00000000 : rd_value;
        // Unmapped offsets and writes to read-only words fail
        pslverr <= !addr_ok || (pwrite && (paddr != `CFG_OFFSET));
      end
    end
  end

  // config word loaded on accepted write
  // idle below hold is the master's fault, not checked
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_quota_reg <= `RST_HOLD_QUOTA;
      idle_quota_reg <= `RST_IDLE_QUOTA;
      region_split <= `RST_SPLIT;
      reflect_reg <= `RST_REFLECT;
    end
    else if (apb_write && (paddr == `CFG_OFFSET))
    begin
      hold_quota_reg <= pwdata[`CFG_HOLD_LSB +: QUOTA_W];
      idle_quota_reg <= pwdata[`CFG_IDLE_LSB +: QUOTA_W];
      region_split <= pwdata[`CFG_SPLIT_BIT];
      reflect_reg <= pwdata[`CFG_REFLECT_BIT];
    end
  end

  // One engine, idle detector and token queue per port
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : port_gen
      localparam int O = 1 - g;
      fair_if #(.QW(QUOTA_W), .XW(XFER_W), .CW(CNT_W)) fif ();

      assign fif.tok_in = rx_sat[g] && rx_sync[g];
      assign rev_in[g] = rx_sat_rev[g] && rx_sync[g];
      // timer restarts only on SAT output
      assign fif.tmr_clr = tok_rel[g] && (reflect_reg || port_oper[O]);
      assign fif.app_pending = app_pending[g];
      // idle needs the feeding link at FLAGs
      assign fif.no_cut = !fwd_pending[g] && link_idle_reg[O];
      assign fif.app_sent = app_sent[g];
      assign fif.hold_quota = hold_quota_reg;
      assign fif.idle_quota = idle_quota_reg;
      assign fif.xfer = xfer_count[g];
      assign tok_rel[g] = fif.tok_release;
      assign holding[g] = fif.holding;
      assign sat_now[g] = fif.satisfied;
      assign grant_now[g] = fif.grant;
      assign cnt[g] = fif.cnt;

      sat_engine #(.CNT_W(CNT_W), .LOSS_CYCLES(LOSS_CYCLES)) u_engine (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .f(fif.eng)
      );

      // forward SAT from the other port
      // reflect SAT back out this port
      // string end turns SAT' into SAT
      assign sat_set[g] = (tok_rel[g] && reflect_reg) ||
                          (tok_rel[O] && !reflect_reg && port_oper[g]) ||
                          (rev_in[g] && !reflect_reg && !port_oper[O]);
      // string end turns SAT into SAT'
      assign rev_set[g] = (tok_rel[g] && !reflect_reg && !port_oper[O]) ||
                          (rev_in[g] && reflect_reg) ||
                          (rev_in[O] && !reflect_reg && port_oper[g]);
      // New token wins over a take in the same cycle
      assign sat_pend_next[g] = (sat_pend_reg[g] && !tx_sat_taken[g]) ||
                                sat_set[g];
      assign rev_pend_next[g] = (rev_pend_reg[g] && !tx_rev_taken[g]) ||
                                rev_set[g];

      // Pending tokens merge, as duplicates would anyway
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          sat_pend_reg[g] <= 1'b0;
          rev_pend_reg[g] <= 1'b0;
        end
        else
        begin
          sat_pend_reg[g] <= sat_pend_next[g];
          rev_pend_reg[g] <= rev_pend_next[g];
        end
      end

      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          tx_sat_req[g] <= 1'b0;
          tx_rev_req[g] <= 1'b0;
        end
        else
        begin
          tx_sat_req[g] <= sat_pend_next[g] && port_ready[g];
          tx_rev_req[g] <= rev_pend_next[g] && port_ready[g];
        end
      end

      // two FLAGs in a row mean idle
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          flag_seen_reg[g] <= 1'b0;
          link_idle_reg[g] <= 1'b0;
        end
        else if (rx_other[g])
        begin
          // Any other character ends the idle run
          flag_seen_reg[g] <= 1'b0;
          link_idle_reg[g] <= 1'b0;
        end
        else if (rx_flag[g])
        begin
          flag_seen_reg[g] <= 1'b1;
          link_idle_reg[g] <= flag_seen_reg[g];
        end
      end

      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          orig_grant[g] <= 1'b0;
          cut_stall[g] <= 1'b0;
          satisfied[g] <= 1'b0;
        end
        else
        begin
          orig_grant[g] <= grant_now[g];
          cut_stall[g] <= holding[g] && !sat_now[g];
          satisfied[g] <= sat_now[g];
        end
      end
    end
  endgenerate

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_forward_sat;
    tok_rel[0] && !reflect_reg && port_oper[1] && port_ready[1]
      |=> tx_sat_req[1];
  endproperty
  a_forward_sat: assert property (p_forward_sat)
    else $error("released SAT not forwarded to other port");
  property p_reflect_sat;
    tok_rel[1] && reflect_reg && port_ready[1] |=> tx_sat_req[1];
  endproperty
  a_reflect_sat: assert property (p_reflect_sat)
    else $error("released SAT not reflected on same port");
  property p_reflect_rev;
    rev_in[0] && reflect_reg && port_ready[0] |=> tx_rev_req[0];
  endproperty
  a_reflect_rev: assert property (p_reflect_rev)
    else $error("SAT' not bounced in reflect mode");
  property p_pass_rev;
    rev_in[1] && !reflect_reg && port_oper[0] && port_ready[0]
      |=> tx_rev_req[0];
  endproperty
  a_pass_rev: assert property (p_pass_rev)
    else $error("SAT' not passed to opposite port");
  property p_end_rev_to_sat;
    rev_in[0] && !reflect_reg && !port_oper[1] && port_ready[0]
      |=> tx_sat_req[0] && $stable(cnt[0]);
  endproperty
  a_end_rev_to_sat: assert property (p_end_rev_to_sat)
    else $error("string end did not return SAT' as SAT");
  property p_end_sat_to_rev;
    tok_rel[0] && !reflect_reg && !port_oper[1] && port_ready[0]
      |=> tx_rev_req[0];
  endproperty
  a_end_sat_to_rev: assert property (p_end_sat_to_rev)
    else $error("string end did not return SAT as SAT'");
  property p_ready_only;
    (tx_sat_req[0] || tx_rev_req[0]) |-> $past(port_ready[0]);
  endproperty
  a_ready_only: assert property (p_ready_only)
    else $error("token requested outside Ready");
  property p_idle_two_flags;
    rx_flag[1] && !rx_other[1] ##1 rx_flag[1] && !rx_other[1]
      |=> link_idle_reg[1];
  endproperty
  a_idle_two_flags: assert property (p_idle_two_flags)
    else $error("two FLAGs did not mark link idle");
  property p_cfg_load;
    apb_write && (paddr == `CFG_OFFSET)
      |=> reflect_reg == $past(pwdata[`CFG_REFLECT_BIT]);
  endproperty
  a_cfg_load: assert property (p_cfg_load)
    else $error("config write did not load reflect flag");
  c_forward: cover property (tok_rel[0] ##1 tx_sat_req[1]);
  c_string_end: cover property (rev_in[0] && !port_oper[1]);
  c_reflect: cover property (reflect_reg && tok_rel[1]);
endmodule

//--- test/ring_peer_model.sv
// Peer ports beside the token block: take each token request
// after a short or long wait, as a line transmitter would.
// Assumes a request stands until its taken pulse is seen.
`timescale 1ns/1ps
module ring_peer_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Requests {SAT' p1, SAT' p0, SAT p1, SAT p0} and pacing
  input wire logic [3:0] req,
  input wire logic slow,
  // Token put on the line
  output logic [3:0] taken
);
  // Cycles each request has waited
  logic [3:0][3:0] wait_reg;
  // Send only after the request stood long enough
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      taken <= '0;
      wait_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        taken[i] <= 1'h0;
        wait_reg[i] <= '0;
        // Request still high the cycle after taken: no resend in that cycle
        if (req[i] && !taken[i])
        begin
          if (wait_reg[i] >= (slow ? 4'h6 : 4'h0))
            taken[i] <= 1'h1;
          else
            wait_reg[i] <= wait_reg[i] + 4'h1;
        end
      end
    end
  end
endmodule

//--- test/ring_fairness_token_control_test.sv
// Bench for the ring fairness token block: APB, token pulses and
// traffic flags driven here; checks made at the ports.
// Assumes the peer model answers every token request.
`timescale 1ns/1ps
module ring_fairness_token_control_test;
  // Token case: inputs, then expected {SAT' p1..p0, SAT p1..p0}
  typedef struct packed {
    logic refl;
    logic [1:0] oper;
    logic rev;
    logic p;
    logic [3:0] exp;
  } row_type;
  localparam int LOSS = 4000;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] rx_sync, port_ready, port_oper, rx_sat, rx_sat_rev;
  logic [1:0] rx_flag, rx_other, tx_sat_req, tx_rev_req;
  logic [1:0][3:0] xfer_count;
  logic [1:0] app_pending, fwd_pending, app_sent, orig_grant, cut_stall;
  logic [1:0] satisfied;
  logic region_split, err, slow;
  logic [3:0] seen, acc, taken_v;
  int mismatches, checked, n;
  row_type rows [8] = '{
    9'b0_11_0_0_0010, 9'b0_11_0_1_0001,
    9'b0_11_1_0_1000, 9'b0_11_1_1_0100,
    9'b1_11_0_1_0010, 9'b1_11_1_0_0100,
    9'b0_01_0_0_0100, 9'b0_01_1_0_0001};
  ring_fairness_token_control #(.LOSS_CYCLES(LOSS)) uut (
    .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_sync(rx_sync),
    .port_ready(port_ready), .port_oper(port_oper), .rx_sat(rx_sat),
    .rx_sat_rev(rx_sat_rev), .rx_flag(rx_flag), .rx_other(rx_other),
    .tx_sat_req(tx_sat_req), .tx_rev_req(tx_rev_req),
    .tx_sat_taken(taken_v[1:0]), .tx_rev_taken(taken_v[3:2]),
    .xfer_count(xfer_count), .app_pending(app_pending),
    .fwd_pending(fwd_pending), .app_sent(app_sent),
    .orig_grant(orig_grant), .cut_stall(cut_stall),
    .satisfied(satisfied), .region_split(region_split));
  // Far-side ports taking tokens
  ring_peer_model peer (.ref_clk(ref_clk), .arst_n(arst_n),
    .req({tx_rev_req, tx_sat_req}), .slow(slow), .taken(taken_v));
  // 100 MHz clock
  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Verdict and end of run
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input string what, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, e, s);
    end
  endtask
  // A wait that ran out ends the run
  task automatic hang();
    chk("wait done", 32'h0, 32'h1);
    complete_run();
  endtask
  // One APB transfer; waits on pready, bounded
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (n > 50)
        hang();
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // One-cycle pulse: 0 SAT, 1 SAT', 2 frame sent, 3 FLAG, 4 other
  task automatic pulse(input int k, input logic p);
    @(posedge ref_clk);
    case (k)
      0: rx_sat[p] <= 1'h1;
      1: rx_sat_rev[p] <= 1'h1;
      2: app_sent[p] <= 1'h1;
      3: rx_flag[p] <= 1'h1;
      default: rx_other[p] <= 1'h1;
    endcase
    @(posedge ref_clk);
    {rx_sat, rx_sat_rev, app_sent, rx_flag, rx_other} <= '0;
  endtask
  // First token request seen must match; then let it drain
  task automatic wait_req(input logic [3:0] e);
    n = 0;
    seen = 4'h0;
    while (seen == 4'h0)
    begin
      @(posedge ref_clk);
      seen = {tx_rev_req, tx_sat_req};
      n++;
      if (n > 60)
        hang();
    end
    chk("token request", 32'(seen), 32'(e));
    while ({tx_rev_req, tx_sat_req} !== 4'h0)
    begin
      @(posedge ref_clk);
      n++;
      if (n > 120)
        hang();
    end
  endtask
  // No token request at all for k cycles
  task automatic quiet(input int k);
    acc = 4'h0;
    repeat (k)
    begin
      @(posedge ref_clk);
      acc = acc | {tx_rev_req, tx_sat_req};
    end
    chk("no request", 32'(acc), 32'h0);
  endtask
  // Main sequence
  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, slow} = '0;
    {rx_sat, rx_sat_rev, rx_flag, rx_other, app_sent} = '0;
    {rx_sync, port_ready, port_oper} = '1;
    {app_pending, fwd_pending} = '0;
    xfer_count = {4'h1, 4'h2};
    mismatches = 0;
    checked = 0;
    repeat (5) @(posedge ref_clk);
    chk("pready in reset", 32'(pready), 32'h0);
    chk("requests in reset", 32'({tx_rev_req, tx_sat_req}), 32'h0);
    arst_n <= 1'h1;
    apb(1'h0, 8'h00, 32'h0);
    chk("cfg reset", rd, 32'h0000_0401);
    apb(1'h0, 8'h0C, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'h1, 8'h08, 32'hFFFF_FFFF);
    chk("ro write err", 32'(err), 32'h1);
    apb(1'h1, 8'h00, 32'h0001_0401);
    // Write lands at the access edge; look one edge later
    @(posedge ref_clk);
    chk("split out", 32'(region_split), 32'h1);
    // Forward, reflect and string-end cases, prompt and slow peer
    for (int i = 0; i < 8; i++)
    begin
      slow <= i[0];
      port_oper <= rows[i].oper;
      port_ready <= rows[i].oper;
      apb(1'h1, 8'h00, {14'h0, rows[i].refl, 17'h0401});
      pulse(int'(rows[i].rev), rows[i].p);
      wait_req(rows[i].exp);
    end
    {port_oper, port_ready} <= '1;
    apb(1'h1, 8'h00, 32'h0000_0401);
    // Held token with cut-through waiting; limit 1 x 2 transfers
    {fwd_pending, app_pending} <= 4'h5;
    quiet(5);
    chk("no grant", 32'(orig_grant[0]), 32'h0);
    pulse(0, 1'h0);
    quiet(8);
    chk("stall", 32'(cut_stall[0]), 32'h1);
    chk("grant held", 32'(orig_grant[0]), 32'h1);
    pulse(0, 1'h0);
    pulse(2, 1'h0);
    quiet(4);
    pulse(2, 1'h0);
    wait_req(4'b0010);
    quiet(20);
    apb(1'h0, 8'h08, 32'h0);
    chk("count cleared", 32'(rd[11:0]), 32'h0);
    // Idle limit 4 x 2 transfers, no token; feeding link at FLAGs
    fwd_pending <= 2'h0;
    pulse(3, 1'h1);
    pulse(3, 1'h1);
    quiet(4);
    chk("idle grant", 32'(orig_grant[0]), 32'h1);
    repeat (3) pulse(2, 1'h0);
    fwd_pending <= 2'h1;
    quiet(4);
    chk("between limits", 32'(orig_grant[0]), 32'h0);
    fwd_pending <= 2'h0;
    repeat (5) pulse(2, 1'h0);
    quiet(4);
    chk("at idle limit", 32'(orig_grant[0]), 32'h0);
    apb(1'h0, 8'h08, 32'h0);
    chk("count", 32'(rd[11:0]), 32'h8);
    pulse(0, 1'h0);
    wait_req(4'b0010);
    quiet(4);
    chk("grant again", 32'(orig_grant[0]), 32'h1);
    // Two FLAGs mark the link idle, another character ends it
    pulse(4, 1'h1);
    pulse(3, 1'h1);
    apb(1'h0, 8'h04, 32'h0);
    chk("one flag", 32'(rd[7]), 32'h0);
    pulse(3, 1'h1);
    apb(1'h0, 8'h04, 32'h0);
    chk("idle", 32'(rd[7]), 32'h1);
    pulse(4, 1'h1);
    apb(1'h0, 8'h04, 32'h0);
    chk("busy", 32'(rd[7]), 32'h0);
    // Back-to-back FLAGs on port 1
    @(posedge ref_clk);
    rx_flag <= 2'h2;
    repeat (2) @(posedge ref_clk);
    rx_flag <= 2'h0;
    apb(1'h0, 8'h04, 32'h0);
    chk("flag run", 32'(rd[7]), 32'h1);
    // Out port not Ready, then lost sync
    app_pending <= 2'h0;
    port_ready <= 2'h1;
    pulse(0, 1'h0);
    quiet(10);
    port_ready <= 2'h3;
    wait_req(4'b0010);
    rx_sync <= 2'h2;
    pulse(0, 1'h0);
    pulse(1, 1'h0);
    quiet(10);
    rx_sync <= 2'h3;
    // Second reset, then the loss timer makes a token
    arst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    chk("pready in 2nd reset", 32'(pready), 32'h0);
    arst_n <= 1'h1;
    n = 0;
    while (tx_sat_req === 2'h0 && n < LOSS + 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("loss time", 32'(n >= LOSS - 5 && n <= LOSS + 20), 32'h1);
    complete_run();
  end
endmodule
